// ---- hw/calpin_pkg.sv ----
package calpin_pkg;

   // Register byte offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_RANGE = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_CAL_COUNT = 4'hC;

   // Control register fields
   localparam int CTRL_TUNE_BIT = 0;
   localparam int CTRL_EXT_BIT = 1;
   localparam int CTRL_DES_EN_BIT = 2;
   localparam int CTRL_DES_Q_BIT = 3;
   localparam int CTRL_WIDTH = 3;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   // Status register fields
   localparam int STAT_TUNING_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_SKIPPED_BIT = 2;
   localparam int STAT_SLEEP_BIT = 3;
   localparam int STAT_PDN_BIT = 4;
   localparam int STAT_DES_BIT = 5;
   localparam int STAT_DES_Q_BIT = 6;
   localparam int STAT_STATE_LSB = 8;

   // Full-scale range in millivolts peak-to-peak
   localparam int FSR_WIDTH = 10;
   localparam logic [9:0] FSR_LOW_MV = 10'h258;
   localparam logic [9:0] FSR_HIGH_MV = 10'h320;
   localparam logic [9:0] FSR_MIN_MV = 10'h230;
   localparam logic [9:0] FSR_MAX_MV = 10'h348;
   localparam logic [9:0] RANGE_RESET = 10'h320;

   // Cycle counts
   localparam logic [7:0] QUAL_CYCLES = 8'h0A;
   localparam logic [1:0] SETTLE_CYCLES = 2'h3;
   localparam int DELAY_WIDTH = 24;
   localparam logic [23:0] SHORT_DELAY_DEF = 24'h00_0400;
   localparam logic [23:0] LONG_DELAY_DEF = 24'h01_0000;
   localparam logic [23:0] CAL_CYCLES_DEF = 24'h00_0400;
   localparam int CAL_COUNT_WIDTH = 16;

   typedef enum logic [1:0] {
      ST_SETTLE = 2'b00,
      ST_DELAY = 2'b01,
      ST_IDLE = 2'b10,
      ST_CAL = 2'b11
   } cal_state_t;

   // Control pins as they arrive from the board
   typedef struct packed {
      logic tune;
      logic wait_sel;
      logic wait_float;
      logic sleep;
      logic range_sel;
      logic edge_sel;
      logic drive_sel;
      logic clk_present;
   } pins_t;

   localparam int PIN_COUNT = 8;

   // Converter input routing
   typedef struct packed {
      logic i_pair_en;
      logic q_pair_en;
      logic q_conv_from_i;
      logic i_conv_from_q;
      logic q_conv_falling;
      logic demux_4to1;
   } route_t;

endpackage : calpin_pkg

// ---- hw/tune_qualifier.sv ----
`timescale 1ns/1ps
`default_nettype none

module tune_qualifier
   import calpin_pkg::*;
#(
   parameter logic [7:0] QUAL = QUAL_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic clear,
   input wire logic level,
   output logic fire
);

   logic [7:0] low_cnt_ff;
   logic [7:0] high_cnt_ff;
   logic fire_ff;
   logic armed;

   assign armed = (low_cnt_ff == QUAL);
   assign fire = fire_ff;

   // Low phase, then high phase; a short phase starts over
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_cnt_ff <= 8'h00;
         high_cnt_ff <= 8'h00;
         fire_ff <= 1'b0;
      end else if (ce) begin
         fire_ff <= 1'b0;
         if (clear) begin
            low_cnt_ff <= 8'h00;
            high_cnt_ff <= 8'h00;
         end else if (!level) begin
            high_cnt_ff <= 8'h00;
            if (high_cnt_ff != 8'h00) begin
               low_cnt_ff <= 8'h01;
            end else if (!armed) begin
               low_cnt_ff <= low_cnt_ff + 8'h01;
            end
         end else if (!armed) begin
            low_cnt_ff <= 8'h00;
         end else if (high_cnt_ff == QUAL - 8'h01) begin
            // Tenth high cycle: request accepted, low phase consumed
            fire_ff <= 1'b1;
            low_cnt_ff <= 8'h00;
            high_cnt_ff <= 8'h00;
         end else begin
            high_cnt_ff <= high_cnt_ff + 8'h01;
         end
      end
   end

endmodule : tune_qualifier

`default_nettype wire

// ---- hw/adc_cal_pin_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

module adc_cal_pin_ctrl
   import calpin_pkg::*;
#(
   parameter logic [23:0] SHORT_DELAY = SHORT_DELAY_DEF,
   parameter logic [23:0] LONG_DELAY = LONG_DELAY_DEF,
   parameter logic [23:0] CAL_CYCLES = CAL_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic tune_request_pin,
   input wire logic startup_wait_select,
   input wire logic startup_wait_float,
   input wire logic sleep_pin,
   input wire logic input_range_select,
   input wire logic output_edge_select,
   input wire logic drive_level_select,
   input wire logic clk_present,
   output logic tuning_in_progress,
   output logic analog_power_down,
   output logic [9:0] fsr_mv,
   output logic data_on_rising_edge,
   output logic drive_strong,
   output route_t route
);

   pins_t pins_raw;
   logic [PIN_COUNT-1:0] sync1_ff;
   logic [PIN_COUNT-1:0] sync2_ff;
   pins_t pin;

   cal_state_t state_ff;
   cal_state_t nxt_state;
   logic [1:0] settle_cnt_ff;
   logic [23:0] delay_cnt_ff;
   logic [23:0] cal_cnt_ff;
   logic [23:0] delay_target;
   logic delay_done;
   logic cal_done;
   logic skipped_ff;
   logic done_ff;
   logic [15:0] cal_count_ff;

   logic [2:0] ctrl_ff;
   logic [9:0] range_ff;
   logic [9:0] nxt_range;
   logic sw_tune_ff;
   logic ack_ff;
   logic [31:0] readdata_ff;
   logic [31:0] nxt_readdata;
   logic bus_req;
   logic wr_take;

   logic ext_mode;
   logic asleep;
   logic pin_fire;
   logic tune_go;
   logic des_on;
   logic des_q;

   logic tuning_ff;
   logic pdn_ff;
   logic [9:0] fsr_ff;
   logic rising_ff;
   logic strong_ff;
   route_t route_ff;

   assign pins_raw = '{
      tune: tune_request_pin,
      wait_sel: startup_wait_select,
      wait_float: startup_wait_float,
      sleep: sleep_pin,
      range_sel: input_range_select,
      edge_sel: output_edge_select,
      drive_sel: drive_level_select,
      clk_present: clk_present
   };

   // Two-flop synchronisers, one per pin
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
            end else if (ce) begin
               sync1_ff[gi] <= pins_raw[gi];
               sync2_ff[gi] <= sync1_ff[gi];
            end
         end
      end
   endgenerate

   assign pin = pins_t'(sync2_ff);

   // Mode decode
   assign ext_mode = ctrl_ff[CTRL_EXT_BIT - 1];
   // Sleep waits for a running calibration to finish
   assign asleep = pin.sleep && (state_ff != ST_CAL);
   // Floating pin selects dual edge in normal mode only
   assign des_on = ext_mode ? ctrl_ff[CTRL_DES_EN_BIT - 1] : pin.wait_float;
   assign des_q = ext_mode && ctrl_ff[CTRL_DES_Q_BIT - 1];

   // Request qualifier on the sample clock
   tune_qualifier #(
      .QUAL(QUAL_CYCLES)
   ) u_qual (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .clear(asleep),
      .level(pin.tune),
      .fire(pin_fire)
   );

   // Software requests obey the same power-down gating as the pin
   assign tune_go = (pin_fire || sw_tune_ff) && !asleep;

   // Delay length; extended mode and dual edge force the short one
   always_comb begin
      if (ext_mode || pin.wait_float) begin
         delay_target = SHORT_DELAY;
      end else if (pin.wait_sel) begin
         delay_target = LONG_DELAY;
      end else begin
         delay_target = SHORT_DELAY;
      end
   end

   assign delay_done = (delay_cnt_ff >= delay_target - 24'h00_0001);
   assign cal_done = (cal_cnt_ff == CAL_CYCLES - 24'h00_0001);

   // Sequencer next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_SETTLE: begin
            if (settle_cnt_ff == SETTLE_CYCLES) begin
               // Pin high at power-up: no automatic calibration
               nxt_state = pin.tune ? ST_IDLE : ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (tune_go) begin
               nxt_state = ST_CAL;
            end else if (!pin.sleep && pin.clk_present && delay_done) begin
               nxt_state = ST_CAL;
            end
         end
         ST_IDLE: begin
            if (tune_go) begin
               nxt_state = ST_CAL;
            end
         end
         ST_CAL: begin
            if (cal_done && pin.clk_present) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_SETTLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_SETTLE;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   // Let the synchronisers fill before the strap is judged
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         settle_cnt_ff <= 2'h0;
      end else if (ce && state_ff == ST_SETTLE) begin
         settle_cnt_ff <= settle_cnt_ff + 2'h1;
      end
   end

   // Power-on delay counter; frozen by sleep or a missing clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         delay_cnt_ff <= 24'h00_0000;
      end else if (ce && state_ff == ST_DELAY) begin
         if (!pin.sleep && pin.clk_present && !delay_done) begin
            delay_cnt_ff <= delay_cnt_ff + 24'h00_0001;
         end
      end
   end

   // Calibration length counter; advances only with a live clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cal_cnt_ff <= 24'h00_0000;
      end else if (ce) begin
         if (state_ff != ST_CAL) begin
            cal_cnt_ff <= 24'h00_0000;
         end else if (pin.clk_present && !cal_done) begin
            cal_cnt_ff <= cal_cnt_ff + 24'h00_0001;
         end
      end
   end

   // Calibration history for software
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         skipped_ff <= 1'b0;
         done_ff <= 1'b0;
         cal_count_ff <= 16'h0000;
      end else if (ce) begin
         if (state_ff == ST_SETTLE && nxt_state == ST_IDLE) begin
            skipped_ff <= 1'b1;
         end
         if (state_ff == ST_CAL && nxt_state == ST_IDLE) begin
            done_ff <= 1'b1;
            skipped_ff <= 1'b0;
            cal_count_ff <= cal_count_ff + 16'h0001;
         end
      end
   end

   // Status outputs, registered
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tuning_ff <= 1'b0;
         pdn_ff <= 1'b0;
      end else if (ce) begin
         tuning_ff <= (nxt_state == ST_CAL);
         // Waiting logic without a clock keeps the analog side down
         pdn_ff <= asleep || (!pin.clk_present && state_ff != ST_IDLE);
      end
   end

   // Range, edge and drive selection
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fsr_ff <= FSR_HIGH_MV;
         rising_ff <= 1'b0;
         strong_ff <= 1'b0;
      end else if (ce) begin
         fsr_ff <= ext_mode ? range_ff : (pin.range_sel ? FSR_HIGH_MV : FSR_LOW_MV);
         rising_ff <= pin.edge_sel;
         strong_ff <= pin.drive_sel;
      end
   end

   // Converter routing for dual edge sampling
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         route_ff <= '0;
      end else if (ce) begin
         route_ff.i_pair_en <= !des_on || !des_q;
         route_ff.q_pair_en <= !des_on || des_q;
         route_ff.q_conv_from_i <= des_on && !des_q;
         route_ff.i_conv_from_q <= des_on && des_q;
         route_ff.q_conv_falling <= des_on;
         route_ff.demux_4to1 <= des_on;
      end
   end

   assign tuning_in_progress = tuning_ff;
   assign analog_power_down = pdn_ff;
   assign fsr_mv = fsr_ff;
   assign data_on_rising_edge = rising_ff;
   assign drive_strong = strong_ff;
   assign route = route_ff;

   // Avalon slave: one wait cycle, then answer
   assign bus_req = (read || write) && !(read && write);
   assign waitrequest = bus_req && !(ack_ff && ce); // Frozen enable keeps the master waiting
   assign wr_take = write && !read && ack_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_ff <= 1'b0;
      end else if (ce) begin
         ack_ff <= bus_req && !ack_ff;
      end
   end

   // Range writes clamp into the legal extended span
   always_comb begin
      nxt_range = range_ff;
      if (byteenable[0]) begin
         nxt_range[7:0] = writedata[7:0];
      end
      if (byteenable[1]) begin
         nxt_range[9:8] = writedata[9:8];
      end
      if (nxt_range < FSR_MIN_MV) begin
         nxt_range = FSR_MIN_MV;
      end else if (nxt_range > FSR_MAX_MV) begin
         nxt_range = FSR_MAX_MV;
      end
   end

   // Register writes; the tune bit is a self-clearing strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= CTRL_RESET;
         range_ff <= RANGE_RESET;
         sw_tune_ff <= 1'b0;
      end else if (ce) begin
         sw_tune_ff <= 1'b0;
         if (wr_take && address == OFS_CTRL && byteenable[0]) begin
            ctrl_ff <= writedata[CTRL_DES_Q_BIT:CTRL_EXT_BIT];
            sw_tune_ff <= writedata[CTRL_TUNE_BIT];
         end else if (wr_take && address == OFS_RANGE) begin
            range_ff <= nxt_range;
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      nxt_readdata = 32'h0000_0000;
      if (address == OFS_CTRL) begin
         nxt_readdata[CTRL_DES_Q_BIT:CTRL_EXT_BIT] = ctrl_ff;
      end else if (address == OFS_RANGE) begin
         nxt_readdata[FSR_WIDTH-1:0] = fsr_ff;
      end else if (address == OFS_STATUS) begin
         nxt_readdata[STAT_TUNING_BIT] = tuning_ff;
         nxt_readdata[STAT_DONE_BIT] = done_ff;
         nxt_readdata[STAT_SKIPPED_BIT] = skipped_ff;
         nxt_readdata[STAT_SLEEP_BIT] = asleep;
         nxt_readdata[STAT_PDN_BIT] = pdn_ff;
         nxt_readdata[STAT_DES_BIT] = route_ff.demux_4to1;
         nxt_readdata[STAT_DES_Q_BIT] = route_ff.i_conv_from_q;
         nxt_readdata[STAT_STATE_LSB +: 2] = state_ff;
      end else if (address == OFS_CAL_COUNT) begin
         nxt_readdata[CAL_COUNT_WIDTH-1:0] = cal_count_ff;
      end
   end

   // Read data captured in the wait cycle, stands at the answer edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         readdata_ff <= 32'h0000_0000;
      end else if (ce && read && !write && !ack_ff) begin
         readdata_ff <= nxt_readdata;
      end
   end

   assign readdata = readdata_ff;

endmodule : adc_cal_pin_ctrl

`default_nettype wire

// ---- testbench/calpin_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module calpin_asserts
   import calpin_pkg::*;
#(
   parameter logic [23:0] CAL_CYCLES = CAL_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic sleep_pin,
   input wire logic output_edge_select,
   input wire logic drive_level_select,
   input wire logic clk_present,
   input wire logic tuning_in_progress,
   input wire logic analog_power_down,
   input wire logic [9:0] fsr_mv,
   input wire logic data_on_rising_edge,
   input wire logic drive_strong,
   input wire route_t route
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic [23:0] run_ff;

   // Live calibration cycles; stalls with the clock as the sequencer does
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_ff <= 24'h00_0000;
      end else if (!tuning_in_progress) begin
         run_ff <= 24'h00_0000;
      end else if (ce && clk_present) begin
         run_ff <= run_ff + 24'h00_0001;
      end
   end

   // Calibration runs its full length
   property p_cal_len;
      $fell(tuning_in_progress) |-> run_ff == CAL_CYCLES;
   endproperty
   a_cal_len: assert property (p_cal_len)
      else $error("calibration length wrong");

   // Pin copies settle within the sync latency
   property p_edge;
      (ce && $stable(output_edge_select))[*5] |-> data_on_rising_edge == output_edge_select;
   endproperty
   a_edge: assert property (p_edge)
      else $error("edge select not followed");

   property p_drive;
      (ce && $stable(drive_level_select))[*5] |-> drive_strong == drive_level_select;
   endproperty
   a_drive: assert property (p_drive)
      else $error("drive level not followed");

   property p_fsr;
      fsr_mv >= FSR_MIN_MV && fsr_mv <= FSR_MAX_MV;
   endproperty
   a_fsr: assert property (p_fsr)
      else $error("range outside limits");

   // Sleep must wait for a running calibration
   property p_awake;
      (tuning_in_progress && clk_present)[*4] |-> !analog_power_down;
   endproperty
   a_awake: assert property (p_awake)
      else $error("powered down during calibration");

   property p_noclk;
      (tuning_in_progress && !clk_present && ce)[*4] |-> analog_power_down;
   endproperty
   a_noclk: assert property (p_noclk)
      else $error("analog not held down without clock");

   property p_sleep_block;
      (sleep_pin && ce)[*6] |-> !$rose(tuning_in_progress);
   endproperty
   a_sleep_block: assert property (p_sleep_block)
      else $error("calibration started while asleep");

   property p_des;
      route.demux_4to1 |-> (route.i_pair_en ^ route.q_pair_en)
         && (route.q_conv_from_i ^ route.i_conv_from_q);
   endproperty
   a_des: assert property (p_des)
      else $error("dual edge routing inconsistent");

   c_cal: cover property ($fell(tuning_in_progress));
   c_des: cover property (route.demux_4to1);
   c_sleep: cover property (analog_power_down && sleep_pin);
endmodule : calpin_asserts

bind adc_cal_pin_ctrl calpin_asserts #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.clk(clk), .rst(rst),
   .ce(ce), .sleep_pin(sleep_pin), .output_edge_select(output_edge_select),
   .drive_level_select(drive_level_select), .clk_present(clk_present),
   .tuning_in_progress(tuning_in_progress), .analog_power_down(analog_power_down),
   .fsr_mv(fsr_mv), .data_on_rising_edge(data_on_rising_edge),
   .drive_strong(drive_strong), .route(route));

`default_nettype wire

// ---- testbench/host_pins.sv ----
`timescale 1ns/1ps
`default_nettype none

module host_pins
   import calpin_pkg::*;
(
   input wire logic clk,
   output var pins_t pins
);
   // Quiet board: clock running, all control pins low
   initial pins = 8'h01;

   // Request: low phase then high phase in input clock cycles
   // Waits are scaled far below the seconds a real host allows
   task automatic req(input int lo, input int hi, input logic fin);
      pins.tune <= 1'b0;
      repeat (lo) @(posedge clk);
      pins.tune <= 1'b1;
      repeat (hi) @(posedge clk);
      // Pin left high for the next caller when fin is set; a zero lo, or a zero hi with fin clear, drives it twice in one step
      if (!fin) begin
         pins.tune <= 1'b0;
      end
   endtask : req
endmodule : host_pins

`default_nettype wire

// ---- testbench/adc_calibration_and_pin_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module adc_calibration_and_pin_control_tb
   import calpin_pkg::*;
;
   localparam logic [23:0] SH = 24'h00_0008;
   localparam logic [23:0] LG = 24'h00_0010;
   localparam logic [23:0] CC = 24'h00_0008;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [31:0] readdata, rdv;
   logic waitrequest, tuning_in_progress, analog_power_down, data_on_rising_edge, drive_strong;
   logic [9:0] fsr_mv;
   route_t route;
   pins_t pins;
   int error_cnt = 0;
   int compares = 0;
   int cals, bus_n;

   always #25 clk = ~clk;

   host_pins host (.clk(clk), .pins(pins));

   adc_cal_pin_ctrl #(.SHORT_DELAY(SH), .LONG_DELAY(LG), .CAL_CYCLES(CC)) dut (
      .clk(clk), .rst(rst), .ce(ce), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
      .waitrequest(waitrequest), .tune_request_pin(pins.tune),
      .startup_wait_select(pins.wait_sel), .startup_wait_float(pins.wait_float),
      .sleep_pin(pins.sleep), .input_range_select(pins.range_sel),
      .output_edge_select(pins.edge_sel), .drive_level_select(pins.drive_sel),
      .clk_present(pins.clk_present), .tuning_in_progress(tuning_in_progress),
      .analog_power_down(analog_power_down), .fsr_mv(fsr_mv),
      .data_on_rising_edge(data_on_rising_edge), .drive_strong(drive_strong),
      .route(route));

   task automatic results;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // Avalon cycle; request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      rdv = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
      bus_n = n + 1;
      if (n >= 20) begin
         chk(32'h1, 32'h0);
         results();
      end
   endtask : bus

   // Edges until tuning shows the wanted level
   task automatic wt(input logic lvl, output int n);
      n = 0;
      while (tuning_in_progress !== lvl && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) begin
         chk(32'h1, 32'h0);
         results();
      end
   endtask : wt

   // Power-up: p = tune, wait select, float, sleep; k cycles of sleep or no clock
   task automatic por(input logic [3:0] p, input int k, input logic ext, output int t);
      host.pins[7:4] <= p;
      host.pins.clk_present <= p[0] || k == 0;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t = 0;
      cals = 0;
      if (ext) begin
         bus(1'b1, OFS_CTRL, 32'h0000_0002);
         t = bus_n;
      end
      while (tuning_in_progress !== 1'b1 && t < 200) begin
         @(posedge clk);
         t++;
         if (t == 10 && k > 0) chk(32'(analog_power_down), 32'h1);
         if (t == k) begin
            host.pins.sleep <= 1'b0;
            host.pins.clk_present <= 1'b1;
         end
      end
   endtask : por

   // Finish a calibration and check its length and the tally
   task automatic fin_cal;
      int n;
      wt(1'b0, n);
      chk(32'(n), 32'(CC));
      cals++;
      bus(1'b0, OFS_CAL_COUNT, 32'h0);
      chk(rdv, 32'(cals));
   endtask : fin_cal

   initial begin
      int s0, t, n, v;
      logic [31:0] r;
      int vals[8] = '{0, 559, 560, 700, 840, 841, 1023, 600};
      n = $urandom(32'hd07b2f56);
      por(4'h0, 0, 1'b0, s0);
      fin_cal();
      chk(32'(route), 32'h30);
      por(4'h4, 0, 1'b0, t);
      chk(32'(t - s0), 32'(LG - SH));
      por(4'h4, 0, 1'b1, t);
      chk(32'(t), 32'(s0));
      // Float must win over a long-delay strap
      por(4'h6, 0, 1'b0, t);
      chk(32'(t), 32'(s0));
      chk(32'(route), 32'h2B);
      $display("test 1 done");
      // Clock absent, then sleep held, at power-up; only a window is fixed
      por(4'h0, 20, 1'b0, t);
      chk(32'(t - 20 - s0 >= -4 && t - 20 - s0 <= 3), 32'h1);
      por(4'h1, 30, 1'b0, t);
      chk(32'(t - 30 - s0 >= -4 && t - 30 - s0 <= 3), 32'h1);
      fin_cal();
      host.pins.sleep <= 1'b1;
      repeat (6) @(posedge clk);
      host.req(12, 20, 1'b0);
      host.pins.sleep <= 1'b0;
      repeat (30) @(posedge clk);
      bus(1'b0, OFS_CAL_COUNT, 32'h0);
      chk(rdv, 32'(cals));
      bus(1'b1, OFS_CTRL, 32'h0000_0001);
      wt(1'b1, n);
      host.pins.sleep <= 1'b1;
      fin_cal();
      repeat (4) @(posedge clk);
      chk(32'(analog_power_down), 32'h1);
      host.pins.sleep <= 1'b0;
      $display("test 2 done");
      // Request pin high at power-up, then short and valid requests
      por(4'h8, 0, 1'b0, t);
      chk(32'(t), 32'd200);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(32'(rdv[STAT_SKIPPED_BIT]), 32'h1);
      host.req(9, 12, 1'b1);
      host.req(10, 9, 1'b0);
      repeat (20) @(posedge clk);
      bus(1'b0, OFS_CAL_COUNT, 32'h0);
      chk(rdv, 32'h0);
      host.req(12, 0, 1'b1);
      wt(1'b1, n);
      chk(32'(n), 32'd14);
      fin_cal();
      bus(1'b1, OFS_CTRL, 32'h0000_0001);
      wt(1'b1, n);
      // Clock lost six cycles mid-calibration: analog held down, length stalls
      host.pins.clk_present <= 1'b0;
      repeat (6) @(posedge clk);
      chk(32'(analog_power_down), 32'h1);
      host.pins.clk_present <= 1'b1;
      fin_cal();
      $display("test 3 done");
      // Random pin levels in normal mode
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         host.pins[3:1] <= r[2:0];
         repeat (5) @(posedge clk);
         chk(32'(fsr_mv), r[2] ? 32'(FSR_HIGH_MV) : 32'(FSR_LOW_MV));
         chk(32'(data_on_rising_edge), 32'(r[1]));
         chk(32'(drive_strong), 32'(r[0]));
      end
      // Clock enable low freezes the pin copies
      r = 32'(drive_strong);
      ce <= 1'b0;
      host.pins.drive_sel <= !r[0];
      repeat (6) @(posedge clk);
      chk(32'(drive_strong), r);
      ce <= 1'b1;
      repeat (5) @(posedge clk);
      chk(32'(drive_strong), 32'(!r[0]));
      // Extended mode: clamped range, routing source, unmapped read
      vals[7] = $urandom_range(1023);
      bus(1'b1, OFS_CTRL, 32'h0000_0002);
      foreach (vals[i]) begin
         v = vals[i] < 560 ? 560 : (vals[i] > 840 ? 840 : vals[i]);
         bus(1'b1, OFS_RANGE, 32'(vals[i]));
         bus(1'b0, OFS_RANGE, 32'h0);
         chk(rdv, 32'(v));
         chk(32'(fsr_mv), 32'(v));
      end
      bus(1'b0, 4'h2, 32'h0);
      chk(rdv, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h0000_0006);
      repeat (2) @(posedge clk);
      chk(32'(route), 32'h2B);
      bus(1'b1, OFS_CTRL, 32'h0000_000E);
      repeat (2) @(posedge clk);
      chk(32'(route), 32'h17);
      $display("test 4 done");
      results();
   end
endmodule : adc_calibration_and_pin_control_tb

`default_nettype wire
